/* rtl/sup_pkg.sv */
// How it works
// - Enable low forces every switch off
// - Host holds enable high, low for off
// - Any supply below lockout forces switches off
// - Ready asserted when logic and I/O supplies good
// - Field good asserted above good-rising threshold
// - Field good released below warn, outputs continue
// - After field lockout, off until good-rising again
// - Status pins always follow supplies, no fault
// - Each watchdog runs only while armed
// - Host sends whole-byte frames, whole byte pairs in check mode, each timeout period
// - Host holds strobe high long enough periodically
// - Unused strobe tied high never trips
// - Watchdog trip switches all outputs off
// - Both watchdog timeouts are 1.2 s
// - Trip reported only through link fault flag
// - Flag sent in second byte, check mode only
// - Strobe rise applies all eight together
// - Flag set by either watchdog trip
package sup_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int CHANNELS = 8;
  localparam int BYTE_BITS = 8;
  localparam int FRAME_BITS = 16;
  localparam int CNT_WIDTH = 8;
  // Watchdog timeout, in milliseconds, and in clock cycles
  localparam int WD_TIMEOUT_MS = 1200;
  localparam int WD_TIMEOUT_CYC = (CLK_HZ / 1000) * WD_TIMEOUT_MS;
  // Least strobe high time, rounded up to whole cycles
  localparam int STROBE_MIN_NS = 1000;
  localparam int STROBE_MIN_CYC =
    (STROBE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int STROBE_CNT_WIDTH = 8;
  // Host serial clock half period in cycles
  localparam int SCLK_HALF_CYC = 4;
  // Check byte field positions
  localparam int LINK_FAULT_BIT = 7;
  localparam int SUPPLY_ERR_BIT = 6;
  localparam int THERMAL_BIT = 5;
  // Reset values
  localparam logic [7:0] SWITCH_OFF = 8'h00;
  localparam logic [7:0] STATUS_ZERO = 8'h00;
  localparam logic [4:0] CHECK_ZERO = 5'h00;
endpackage

/* rtl/sup_if.sv */
`timescale 1ns/100ps
interface sup_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic miso;
  logic output_update_strobe;
  logic enable;
  logic serial_watchdog_arm;
  logic strobe_watchdog_arm;
  logic check_code_select;
  logic ready_n;
  logic field_supply_good_n;

  // Released data line reads low through its pulldown
  assign miso = sdo_oe & sdo;

  modport device (
    input sclk, cs_n, sdi, output_update_strobe, enable,
    input serial_watchdog_arm, strobe_watchdog_arm, check_code_select,
    output sdo, sdo_oe, ready_n, field_supply_good_n
  );
  modport host (
    output sclk, cs_n, sdi, output_update_strobe, enable,
    output serial_watchdog_arm, strobe_watchdog_arm, check_code_select,
    input miso, ready_n, field_supply_good_n
  );
endinterface

/* rtl/output_safety_supervisor.sv */
`timescale 1ns/100ps
module output_safety_supervisor #(
  parameter int WD_TIMEOUT_CYC = sup_pkg::WD_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Pins to the host
  sup_if.device link,
  // Supply comparators, high while above threshold
  input wire logic i_field_above_good_rise,
  input wire logic i_field_above_warn,
  input wire logic i_field_above_lockout_fall,
  input wire logic i_analog_supply_ok,
  input wire logic i_io_supply_ok,
  input wire logic i_internal_logic_supply_ok,
  // Switch drive and status
  output logic [sup_pkg::CHANNELS-1:0] o_switch,
  output logic o_link_fault_flag
);
  localparam int WDW = $clog2(WD_TIMEOUT_CYC + 1);
  localparam int NPIN = 14;

  function automatic logic frame_ok(
    input logic [sup_pkg::CNT_WIDTH-1:0] cnt,
    input logic check
  );
    logic mult8;
    mult8 = (cnt[2:0] == 3'h0) && (cnt != '0);
    frame_ok = mult8 && (!check || !cnt[3]);
  endfunction

  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;
  logic sclk_prev;
  logic cs_prev;
  logic strobe_prev;
  logic [sup_pkg::CNT_WIDTH-1:0] bit_cnt;
  logic [sup_pkg::FRAME_BITS-1:0] rx_shift;
  logic [sup_pkg::FRAME_BITS-1:0] tx_shift;
  logic [sup_pkg::CHANNELS-1:0] cmd;
  logic [sup_pkg::CHANNELS-1:0] applied;
  logic sent_flag;
  logic [WDW-1:0] spi_wd_cnt;
  logic [WDW-1:0] strobe_wd_cnt;
  logic spi_trip;
  logic strobe_trip;
  logic [sup_pkg::STROBE_CNT_WIDTH-1:0] strobe_hi_cnt;
  logic field_run;
  logic field_good_n;
  logic sdo_q;
  logic sdo_oe_q;
  logic ready_n_q;

  // Two flip-flops on every pin and comparator input
  always_ff @(posedge i_clk) begin
    pin_meta <= {link.sclk, link.cs_n, link.sdi, link.output_update_strobe,
      link.enable, link.serial_watchdog_arm, link.strobe_watchdog_arm,
      link.check_code_select, i_field_above_good_rise, i_field_above_warn,
      i_field_above_lockout_fall, i_analog_supply_ok, i_io_supply_ok,
      i_internal_logic_supply_ok};
    pin_sync <= pin_meta;
  end

  // Named synchronised levels
  wire sclk_s = pin_sync[13];
  wire cs_n_s = pin_sync[12];
  wire sdi_s = pin_sync[11];
  wire strobe_s = pin_sync[10];
  wire enable_s = pin_sync[9];
  wire spi_arm_s = pin_sync[8];
  wire strobe_arm_s = pin_sync[7];
  wire check_s = pin_sync[6];
  wire good_rise_s = pin_sync[5];
  wire warn_s = pin_sync[4];
  wire lockout_s = pin_sync[3];
  wire analog_s = pin_sync[2];
  wire io_s = pin_sync[1];
  wire logic_s = pin_sync[0];

  // Edge detection on the synchronised pins
  wire sclk_rise = sclk_s & ~sclk_prev & ~cs_n_s;
  wire sclk_fall = ~sclk_s & sclk_prev & ~cs_n_s;
  wire cs_fall = ~cs_n_s & cs_prev;
  wire cs_rise = cs_n_s & ~cs_prev;
  wire strobe_rise = strobe_s & ~strobe_prev;

  // Frame check and command acceptance
  wire frame_valid = cs_rise & frame_ok(bit_cnt, check_s);
  wire comm_ready = io_s & logic_s;
  wire accept = frame_valid & comm_ready;
  wire [sup_pkg::CHANNELS-1:0] rx_cmd = check_s ?
    rx_shift[sup_pkg::FRAME_BITS-1:sup_pkg::BYTE_BITS] :
    rx_shift[sup_pkg::BYTE_BITS-1:0];

  // Watchdog kicks and expiry
  wire strobe_kick = strobe_s &&
    (strobe_hi_cnt == sup_pkg::STROBE_CNT_WIDTH'(sup_pkg::STROBE_MIN_CYC));
  wire spi_expire = spi_arm_s &&
    (spi_wd_cnt == WDW'(WD_TIMEOUT_CYC - 1));
  wire strobe_expire = strobe_arm_s &&
    (strobe_wd_cnt == WDW'(WD_TIMEOUT_CYC - 1));
  wire trip_event = (spi_expire & ~spi_trip) |
    (strobe_expire & ~strobe_trip);
  wire flag_clear = frame_valid & check_s & sent_flag;

  // Output gate: enable, supplies, watchdogs
  wire supplies_ok = field_run & analog_s & io_s & logic_s;
  wire outputs_allowed = enable_s & supplies_ok &
    ~spi_trip & ~strobe_trip;
  wire supply_err = ~supplies_ok;

  // Next status byte pair for the return line
  wire [sup_pkg::BYTE_BITS-1:0] check_byte = {o_link_fault_flag, supply_err,
    1'b0, sup_pkg::CHECK_ZERO};
  wire [sup_pkg::FRAME_BITS-1:0] next_tx = check_s ?
    {sup_pkg::STATUS_ZERO, check_byte} :
    {sup_pkg::STATUS_ZERO, sup_pkg::STATUS_ZERO};
  wire next_flag = trip_event | (o_link_fault_flag & ~flag_clear);

  // Edge history
  always_ff @(posedge i_clk) begin
    sclk_prev <= sclk_s;
    cs_prev <= cs_n_s;
    strobe_prev <= strobe_s;
  end

  // Serial receive: count and shift clocks within one select
  always_ff @(posedge i_clk) begin
    if (i_srst || cs_fall) begin
      bit_cnt <= '0;
      rx_shift <= '0;
    end else if (sclk_rise) begin
      bit_cnt <= bit_cnt + 1'b1;
      rx_shift <= {rx_shift[sup_pkg::FRAME_BITS-2:0], sdi_s};
    end
  end

  // Serial return: load at select, shift on falling clock
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tx_shift <= '0;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
      sent_flag <= 1'b0;
    end else begin
      sdo_oe_q <= ~cs_n_s;
      if (cs_fall) begin
        tx_shift <= next_tx;
        sdo_q <= next_tx[sup_pkg::FRAME_BITS-1];
        sent_flag <= check_s & o_link_fault_flag;
      end else if (sclk_fall) begin
        tx_shift <= {tx_shift[sup_pkg::FRAME_BITS-2:0], 1'b0};
        sdo_q <= tx_shift[sup_pkg::FRAME_BITS-2];
      end
    end
  end

  // Command hold and simultaneous apply on strobe
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cmd <= sup_pkg::SWITCH_OFF;
      applied <= sup_pkg::SWITCH_OFF;
    end else begin
      if (accept) begin
        cmd <= rx_cmd;
      end
      if (accept && strobe_s) begin
        applied <= rx_cmd;
      end else if (strobe_rise) begin
        applied <= cmd;
      end
    end
  end

  // Strobe high-time measurement
  always_ff @(posedge i_clk) begin
    if (i_srst || !strobe_s) begin
      strobe_hi_cnt <= '0;
    end else if (!strobe_kick) begin
      strobe_hi_cnt <= strobe_hi_cnt + 1'b1;
    end
  end

  // Serial watchdog
  always_ff @(posedge i_clk) begin
    if (i_srst || !spi_arm_s) begin
      spi_wd_cnt <= '0;
      spi_trip <= 1'b0;
    end else if (frame_valid) begin
      spi_wd_cnt <= '0;
      spi_trip <= 1'b0;
    end else if (spi_expire) begin
      spi_wd_cnt <= '0;
      spi_trip <= 1'b1;
    end else begin
      spi_wd_cnt <= spi_wd_cnt + 1'b1;
    end
  end

  // Strobe watchdog
  always_ff @(posedge i_clk) begin
    if (i_srst || !strobe_arm_s) begin
      strobe_wd_cnt <= '0;
      strobe_trip <= 1'b0;
    end else if (strobe_kick) begin
      strobe_wd_cnt <= '0;
      strobe_trip <= 1'b0;
    end else if (strobe_expire) begin
      strobe_wd_cnt <= '0;
      strobe_trip <= 1'b1;
    end else begin
      strobe_wd_cnt <= strobe_wd_cnt + 1'b1;
    end
  end

  // Field supply hysteresis and status pins
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      field_run <= 1'b0;
      field_good_n <= 1'b1;
      ready_n_q <= 1'b1;
    end else begin
      if (!lockout_s) begin
        field_run <= 1'b0;
      end else if (good_rise_s) begin
        field_run <= 1'b1;
      end
      if (good_rise_s) begin
        field_good_n <= 1'b0;
      end else if (!warn_s) begin
        field_good_n <= 1'b1;
      end
      ready_n_q <= ~comm_ready;
    end
  end

  // Switch drive and link fault flag; a trip wins over a clear
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_switch <= sup_pkg::SWITCH_OFF;
      o_link_fault_flag <= 1'b0;
    end else begin
      o_switch <= outputs_allowed ? applied : sup_pkg::SWITCH_OFF;
      o_link_fault_flag <= next_flag;
    end
  end

  // Pin drive
  assign link.sdo = sdo_q;
  assign link.sdo_oe = sdo_oe_q;
  assign link.ready_n = ready_n_q;
  assign link.field_supply_good_n = field_good_n;
endmodule // output_safety_supervisor

/* rtl/output_safety_host.sv */
`timescale 1ns/100ps
module output_safety_host #(
  parameter int SCLK_HALF_CYC = sup_pkg::SCLK_HALF_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Pins to the device
  sup_if.host link,
  // Control levels
  input wire logic i_enable,
  input wire logic i_serial_watchdog_arm,
  input wire logic i_strobe_watchdog_arm,
  input wire logic i_check_code_select,
  input wire logic i_output_update_strobe,
  // Command request and answer
  input wire logic i_start,
  input wire logic [sup_pkg::CHANNELS-1:0] i_on_bits,
  output logic o_busy,
  output logic o_done,
  output logic [sup_pkg::FRAME_BITS-1:0] o_status
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOW = 4'b0010,
    ST_HIGH = 4'b0100,
    ST_TRAIL = 4'b1000
  } state_type;

  state_type state;
  logic [7:0] div;
  logic [sup_pkg::CNT_WIDTH-1:0] bits_left;
  logic [sup_pkg::FRAME_BITS-1:0] tx;
  logic [sup_pkg::FRAME_BITS-1:0] rx;
  logic miso_meta;
  logic miso_s;
  logic sclk_q;
  logic cs_n_q;
  logic [4:0] ctl_q;

  wire half_done = (div == 8'(SCLK_HALF_CYC - 1));
  wire [sup_pkg::FRAME_BITS-1:0] next_tx = i_check_code_select ?
    {i_on_bits, 3'h0, sup_pkg::CHECK_ZERO} :
    {i_on_bits, sup_pkg::STATUS_ZERO};
  wire [sup_pkg::CNT_WIDTH-1:0] next_bits = i_check_code_select ?
    sup_pkg::CNT_WIDTH'(sup_pkg::FRAME_BITS) :
    sup_pkg::CNT_WIDTH'(sup_pkg::BYTE_BITS);

  // Return data synchroniser
  always_ff @(posedge i_clk) begin
    miso_meta <= link.miso;
    miso_s <= miso_meta;
  end

  // Control levels registered onto the pins
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctl_q <= 5'h00;
    end else begin
      ctl_q <= {i_enable, i_serial_watchdog_arm, i_strobe_watchdog_arm,
        i_check_code_select, i_output_update_strobe};
    end
  end

  // Frame sequencer with divided serial clock
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= ST_IDLE;
      div <= 8'h00;
      bits_left <= '0;
      tx <= '0;
      rx <= '0;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_status <= '0;
    end else begin
      o_done <= 1'b0;
      div <= half_done ? 8'h00 : div + 8'h01;
      unique case (state)
        ST_IDLE: begin
          div <= 8'h00;
          if (i_start) begin
            cs_n_q <= 1'b0;
            tx <= next_tx;
            bits_left <= next_bits;
            o_busy <= 1'b1;
            state <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (half_done) begin
            sclk_q <= 1'b1;
            state <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (half_done) begin
            sclk_q <= 1'b0;
            rx <= {rx[sup_pkg::FRAME_BITS-2:0], miso_s};
            tx <= {tx[sup_pkg::FRAME_BITS-2:0], 1'b0};
            bits_left <= bits_left - 1'b1;
            state <= (bits_left == 8'h01) ? ST_TRAIL : ST_LOW;
          end
        end
        ST_TRAIL: begin
          if (half_done) begin
            cs_n_q <= 1'b1;
            o_busy <= 1'b0;
            o_done <= 1'b1;
            o_status <= rx;
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Pin drive
  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.sdi = tx[sup_pkg::FRAME_BITS-1];
  assign link.enable = ctl_q[4];
  assign link.serial_watchdog_arm = ctl_q[3];
  assign link.strobe_watchdog_arm = ctl_q[2];
  assign link.check_code_select = ctl_q[1];
  assign link.output_update_strobe = ctl_q[0];
endmodule // output_safety_host

/* tb/output_safety_supervisor_chk.sv */
`timescale 1ns/100ps
module output_safety_supervisor_chk (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Link pins
  input wire logic cs_n,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic enable,
  input wire logic check_code_select,
  input wire logic ready_n,
  input wire logic field_supply_good_n,
  // Supply levels and switch drive
  input wire logic i_field_above_good_rise,
  input wire logic i_field_above_warn,
  input wire logic i_field_above_lockout_fall,
  input wire logic i_analog_supply_ok,
  input wire logic i_io_supply_ok,
  input wire logic i_internal_logic_supply_ok,
  input wire logic [sup_pkg::CHANNELS-1:0] o_switch,
  input wire logic o_link_fault_flag
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // Supply gates combined
  wire logic logic_up = i_io_supply_ok & i_internal_logic_supply_ok;
  wire logic all_up = logic_up & i_analog_supply_ok &
    i_field_above_lockout_fall;
  // Five cycles cover the pin synchronisers and the output register
  sequence en_low_s; !enable [*5]; endsequence
  sequence supply_bad_s; !all_up [*5]; endsequence
  en_off_a: assert property (en_low_s |-> o_switch == '0)
    else $error("switches on while enable low");
  supply_off_a: assert property (supply_bad_s |-> o_switch == '0)
    else $error("switches on during lockout");
  ready_low_a: assert property (logic_up [*5] |-> !ready_n)
    else $error("ready not asserted");
  ready_high_a: assert property (!logic_up [*5] |-> ready_n)
    else $error("ready asserted without supplies");
  fgood_low_a: assert property (
    i_field_above_good_rise [*5] |-> !field_supply_good_n)
    else $error("field good not asserted");
  fgood_high_a: assert property (
    !i_field_above_warn [*5] |-> field_supply_good_n)
    else $error("field good held below warn level");
  oe_on_a: assert property (!cs_n [*5] |-> sdo_oe)
    else $error("data out not driven while selected");
  oe_off_a: assert property (cs_n [*5] |-> !sdo_oe)
    else $error("data out driven while idle");
  sdo_quiet_a: assert property (!check_code_select [*5] |-> !sdo)
    else $error("check byte sent with check codes off");
  trip_off_a: assert property (
    $rose(o_link_fault_flag) |-> ##[0:2] o_switch == '0)
    else $error("switches on after watchdog trip");
endmodule // output_safety_supervisor_chk

/* tb/output_safety_supervisor_tb.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("BAD %0t got %h exp %h", $time, a, b); end end
module output_safety_supervisor_tb;
  localparam int WD = 2000;
  logic i_clk = 0;
  logic i_srst = 1;
  logic en = 1, wd_ser = 0, wd_stb = 0, chk_sel = 0, stb = 1, start = 0;
  logic good_rise = 1, warn = 1, lock_fall = 1, aok = 1, iok = 1, lok = 1;
  logic [7:0] bits = 8'h00;
  logic [7:0] b;
  logic [7:0] sw;
  logic flag, done, busy;
  logic [15:0] status;
  int seed = 99115;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  sup_if link_if ();
  // Device and host joined through the link
  output_safety_supervisor #(.WD_TIMEOUT_CYC(WD))
    output_safety_supervisor_inst (.i_clk(i_clk), .i_srst(i_srst),
    .link(link_if.device), .i_field_above_good_rise(good_rise),
    .i_field_above_warn(warn), .i_field_above_lockout_fall(lock_fall),
    .i_analog_supply_ok(aok), .i_io_supply_ok(iok),
    .i_internal_logic_supply_ok(lok), .o_switch(sw),
    .o_link_fault_flag(flag));
  output_safety_host output_safety_host_inst (.i_clk(i_clk),
    .i_srst(i_srst), .link(link_if.host), .i_enable(en),
    .i_serial_watchdog_arm(wd_ser), .i_strobe_watchdog_arm(wd_stb),
    .i_check_code_select(chk_sel), .i_output_update_strobe(stb),
    .i_start(start), .i_on_bits(bits), .o_busy(busy), .o_done(done),
    .o_status(status));
  output_safety_supervisor_chk chk_inst (.i_clk(i_clk), .i_srst(i_srst),
    .cs_n(link_if.cs_n), .sdo(link_if.sdo), .sdo_oe(link_if.sdo_oe),
    .enable(link_if.enable), .check_code_select(link_if.check_code_select),
    .ready_n(link_if.ready_n),
    .field_supply_good_n(link_if.field_supply_good_n),
    .i_field_above_good_rise(good_rise), .i_field_above_warn(warn),
    .i_field_above_lockout_fall(lock_fall), .i_analog_supply_ok(aok),
    .i_io_supply_ok(iok), .i_internal_logic_supply_ok(lok),
    .o_switch(sw), .o_link_fault_flag(flag));
  // Clock and hang guard
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      final_report;
    end
  end
  // Expected switch drive and check-mode return
  function automatic logic [7:0] exp_sw(input logic [7:0] v, input bit g);
    return g ? v : 8'h00;
  endfunction
  function automatic logic [15:0] exp_stat(input logic f);
    return {8'h00, f, 7'h00};
  endfunction
  task tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // One command frame, then time to apply
  task send(input logic [7:0] v);
    int k;
    @(negedge i_clk);
    start = 1;
    bits = v;
    @(negedge i_clk);
    start = 0;
    `CHK(busy, 1'b1);
    k = 0;
    while (done !== 1'b1 && k < 400) begin
      @(negedge i_clk);
      k++;
    end
    `CHK(busy, 1'b0);
    if (k == 400) err_count++;
    tick(8);
  endtask
  task final_report;
    $display("mismatches %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    tick(16);
    i_srst = 0;
    for (int i = 0; i < 8; i++) begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      send(b);
      `CHK(sw, exp_sw(b, 1));
    end
    stb = 0;
    tick(5);
    send(~b);
    tick(2500);
    `CHK(sw, b);
    stb = 1;
    tick(6);
    `CHK(sw, exp_sw(~b, 1));
    en = 0;
    tick(6);
    `CHK(sw, exp_sw(b, 0));
    en = 1;
    send(b);
    `CHK(sw, exp_sw(b, 1));
    for (int i = 1; i < 4; i++) begin
      {aok, iok, lok} = 3'b111 ^ (3'b1 << (i - 1));
      tick(6);
      `CHK(sw, exp_sw(b, 0));
      `CHK(link_if.ready_n, 1'(i < 3));
      {aok, iok, lok} = 3'b111;
      tick(6);
      send(b);
    end
    {good_rise, warn} = 2'b00;
    tick(6);
    `CHK(link_if.field_supply_good_n, 1'b1);
    `CHK(sw, exp_sw(b, 1));
    lock_fall = 0;
    tick(6);
    `CHK(sw, exp_sw(b, 0));
    {lock_fall, warn} = 2'b11;
    tick(6);
    send(b);
    `CHK(sw, exp_sw(b, 0));
    good_rise = 1;
    tick(6);
    `CHK(link_if.field_supply_good_n, 1'b0);
    send(b);
    `CHK(sw, exp_sw(b, 1));
    {chk_sel, wd_ser} = 2'b11;
    tick(6);
    send(b);
    tick(WD - 300);
    `CHK(sw, exp_sw(b, 1));
    tick(400);
    `CHK(sw, exp_sw(b, 0));
    `CHK(flag, 1'b1);
    send(b);
    `CHK(status, exp_stat(1));
    `CHK(sw, exp_sw(b, 1));
    send(b);
    `CHK(status, exp_stat(0));
    {chk_sel, wd_ser} = 2'b00;
    tick(6);
    send(b);
    `CHK(status[7:0], 8'h00);
    wd_stb = 1;
    tick(2500);
    `CHK(sw, exp_sw(b, 1));
    stb = 0;
    tick(WD + 100);
    `CHK(sw, exp_sw(b, 0));
    stb = 1;
    tick(150);
    `CHK(sw, exp_sw(b, 1));
    final_report;
  end
endmodule // output_safety_supervisor_tb
